//--- ase_alu.sv
// Combinational 8-bit ALU for add, add with carry, AND and arithmetic shift.
// Assumes operands are settled in the same cycle; no state.
`timescale 1ns/1ns
module ase_alu
  import ase_pkg::*;
(
  // Operation and operands
  input wire ase_pkg::ase_op_e i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_carry,
  // Result and flags
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_digit_carry,
  output logic o_zero
);
  // ==========================================================================
  // Adders with explicit carry positions
  wire [4:0] low_sum;
  wire [8:0] full_sum;
  wire carry_in;
  assign carry_in = (i_op == ASE_OP_ADDC) ? i_carry : 1'b0;
  assign low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, carry_in};
  assign full_sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, carry_in};

  always_comb begin
    o_result = i_a & i_b;
    o_carry = i_carry;
    o_digit_carry = 1'b0;
    case (i_op)
      ASE_OP_ADD, ASE_OP_ADDC: begin
        o_result = full_sum[7:0];
        o_carry = full_sum[8];
        o_digit_carry = low_sum[4];
      end
      ASE_OP_AND: begin
        o_result = i_a & i_b;
      end
      ASE_OP_ASR: begin
        o_result = {i_b[7], i_b[7:1]};
        o_carry = i_b[0];
      end
      default: begin
        o_result = i_a & i_b;
      end
    endcase
    o_zero = (o_result == 8'h00);
  end
endmodule : ase_alu

//--- ase_exec.sv
// Execution datapath for the add, AND and shift instruction group.
// Assumes the fetch stage presents one instruction with a valid strobe and
// returns the addressed file register value in the same cycle.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ns
module ase_exec
  import ase_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Instruction issue
  input wire logic i_insn_valid,
  input wire logic [13:0] i_insn,
  input wire logic i_branch_taken,
  // File register read port
  input wire logic [7:0] i_file_rdata,
  // File register write port
  output logic o_file_we,
  output logic [6:0] o_file_addr,
  output logic [7:0] o_file_wdata,
  // Architectural state
  output logic [7:0] o_working_register,
  output logic [15:0] o_indirect_pointer0,
  output logic [15:0] o_indirect_pointer1,
  output logic o_carry_flag,
  output logic o_digit_carry_flag,
  output logic o_zero_flag,
  // Cycle control
  output logic o_busy,
  output logic o_nop_cycle
);
  import ase_pkg::*;

  // ==========================================================================
  // Decode
  function automatic ase_op_e decode_file_op(input logic [5:0] op);
    case (op)
      OP_ADD_FILE: decode_file_op = ASE_OP_ADD;
      OP_ADDC_FILE: decode_file_op = ASE_OP_ADDC;
      OP_AND_FILE: decode_file_op = ASE_OP_AND;
      OP_ASR_FILE: decode_file_op = ASE_OP_ASR;
      default: decode_file_op = ASE_OP_NONE;
    endcase
  endfunction : decode_file_op

  wire [5:0] opcode;
  wire [6:0] faddr;
  wire dest_file;
  wire is_add_imm;
  wire is_and_imm;
  wire is_add_ptr;
  wire is_file;
  wire ase_op_e file_op;
  ase_op_e alu_op;
  wire [7:0] alu_b;
  wire accepted;

  assign opcode = i_insn[OP_HI:OP_LO];
  assign faddr = i_insn[ADDR_W-1:0];
  assign dest_file = i_insn[DEST_BIT];
  assign accepted = i_ce && i_insn_valid && !o_busy;
  assign is_add_imm = (opcode == OP_ADD_IMM);
  assign is_and_imm = (opcode == OP_AND_IMM);
  assign is_add_ptr = (opcode == OP_ADD_PTR) && !i_insn[PTR_ZERO_BIT];
  assign file_op = decode_file_op(opcode);
  assign is_file = (file_op != ASE_OP_NONE);
  assign alu_b = is_file ? i_file_rdata : i_insn[DATA_W-1:0];

  always_comb begin
    alu_op = ASE_OP_NONE;
    if (is_add_imm) begin
      alu_op = ASE_OP_ADD;
    end else if (is_and_imm) begin
      alu_op = ASE_OP_AND;
    end else if (is_file) begin
      alu_op = file_op;
    end
  end

  // ==========================================================================
  // ALU
  wire [7:0] alu_result;
  wire alu_carry;
  wire alu_dc;
  wire alu_zero;

  ase_alu u_alu (
    .i_op(alu_op),
    .i_a(o_working_register),
    .i_b(alu_b),
    .i_carry(o_carry_flag),
    .o_result(alu_result),
    .o_carry(alu_carry),
    .o_digit_carry(alu_dc),
    .o_zero(alu_zero)
  );

  // ==========================================================================
  // Pointer arithmetic: sign-extend, add, drop the carry so the sum wraps
  wire ptr_sel;
  wire [15:0] lit_ext;
  wire [15:0] ptr_cur;
  wire [15:0] ptr_sum;
  assign ptr_sel = i_insn[PTR_SEL_BIT];
  assign lit_ext = {{(PTR_W-LIT6_W){i_insn[LIT6_W-1]}}, i_insn[LIT6_W-1:0]};
  assign ptr_cur = ptr_sel ? o_indirect_pointer1 : o_indirect_pointer0;
  assign ptr_sum = ptr_cur + lit_ext;

  // ==========================================================================
  // Writeback selection
  wire flag_c_we;
  wire flag_dc_we;
  wire wr_accum;
  wire wr_file;
  assign flag_c_we = is_add_imm || (file_op == ASE_OP_ADD) || (file_op == ASE_OP_ADDC)
    || (file_op == ASE_OP_ASR);
  assign flag_dc_we = is_add_imm || (file_op == ASE_OP_ADD) || (file_op == ASE_OP_ADDC);
  assign wr_accum = is_add_imm || is_and_imm || (is_file && !dest_file);
  assign wr_file = is_file && dest_file;

  // ==========================================================================
  // Extra cycles: indirect register with pointer top bit set, and taken flow
  wire hits_indirect;
  wire [1:0] extra;
  assign hits_indirect = (is_file && ((faddr == INDIRECT0_ADDR && o_indirect_pointer0[15])
    || (faddr == INDIRECT1_ADDR && o_indirect_pointer1[15])));
  assign extra = {1'b0, hits_indirect} + {1'b0, i_branch_taken};

  logic [1:0] stall_cnt;
  wire [1:0] next_stall_cnt;
  assign next_stall_cnt = accepted ? extra : (stall_cnt - 2'd1);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      stall_cnt <= 2'd0;
      o_busy <= 1'b0;
      o_nop_cycle <= 1'b0;
    end else if (i_ce) begin
      if (accepted || stall_cnt != 2'd0) begin
        stall_cnt <= next_stall_cnt;
        o_busy <= (next_stall_cnt != 2'd0);
        o_nop_cycle <= accepted ? i_branch_taken : 1'b0;
      end else begin
        o_nop_cycle <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Architectural state
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_working_register <= ACCUM_RST;
      o_indirect_pointer0 <= PTR_RST;
      o_indirect_pointer1 <= PTR_RST;
      o_carry_flag <= 1'b0;
      o_digit_carry_flag <= 1'b0;
      o_zero_flag <= 1'b0;
      o_file_we <= 1'b0;
      o_file_addr <= 7'h00;
      o_file_wdata <= 8'h00;
    end else if (i_ce) begin
      o_file_we <= accepted && wr_file;
      if (accepted) begin
        o_file_addr <= faddr;
        o_file_wdata <= alu_result;
        if (wr_accum) begin
          o_working_register <= alu_result;
        end
        if (alu_op != ASE_OP_NONE) begin
          o_zero_flag <= alu_zero;
        end
        if (flag_c_we) begin
          o_carry_flag <= alu_carry;
        end
        if (flag_dc_we) begin
          o_digit_carry_flag <= alu_dc;
        end
        // Pointer update leaves every flag alone
        if (is_add_ptr && !ptr_sel) begin
          o_indirect_pointer0 <= ptr_sum;
        end
        if (is_add_ptr && ptr_sel) begin
          o_indirect_pointer1 <= ptr_sum;
        end
      end
    end
  end
endmodule : ase_exec

//--- ase_exec_assertions.sv
// Checker for the add and shift execution datapath.
// Assumes it is bound to ase_exec and sees only that module's ports.
`timescale 1ns/1ns
module ase_exec_assertions
  import ase_pkg::*;
(
  // Clock, reset, issue
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_insn_valid,
  input wire logic [13:0] i_insn,
  input wire logic i_branch_taken,
  input wire logic [7:0] i_file_rdata,
  // Results
  input wire logic o_file_we,
  input wire logic [6:0] o_file_addr,
  input wire logic [7:0] o_file_wdata,
  input wire logic [7:0] o_working_register,
  input wire logic o_carry_flag,
  input wire logic o_digit_carry_flag,
  input wire logic o_zero_flag,
  input wire logic o_busy,
  input wire logic o_nop_cycle
);
  // ==========================================================
  // Helpers: values the cycle after an accepted issue must show
  wire acc = i_ce & i_insn_valid & ~o_busy;
  wire [5:0] op = i_insn[13:8];
  wire dbit = i_insn[7];
  wire [6:0] fa = i_insn[6:0];
  wire [8:0] s_imm = o_working_register + i_insn[7:0];
  wire dc_imm = (o_working_register[3:0] + i_insn[3:0]) > 5'h0F;
  wire [8:0] s_file = o_working_register + i_file_rdata;
  wire [7:0] asr = {i_file_rdata[7], i_file_rdata[7:1]};
  wire rd0 = i_file_rdata[0];
  wire fop = op inside {OP_ADD_FILE, OP_ADDC_FILE, OP_AND_FILE, OP_ASR_FILE};
  wire [2:0] flags = {o_carry_flag, o_digit_carry_flag, o_zero_flag};
  wire wz = o_working_register == 8'h00;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ==========================================================
  // Properties
  chk_branch_nop: assert property (acc && i_branch_taken |=> o_nop_cycle && o_busy)
    else $error("no no-op cycle after branch");
  // A low enable freezes the pulse, so only enabled cycles count
  chk_nop_single: assert property (o_nop_cycle && i_ce |=> !o_nop_cycle)
    else $error("no-op cycle too long");
  // Branch plus indirect stretch is the longest stall
  chk_busy_bound: assert property ((o_busy && i_ce) [*2] |=> !o_busy)
    else $error("busy too long");
  chk_ptr_flags: assert property (acc && op == OP_ADD_PTR |=> $stable(flags))
    else $error("pointer add touched flags");
  chk_add_imm: assert property (acc && op == OP_ADD_IMM |=>
    {o_carry_flag, o_working_register} == $past(s_imm) && o_digit_carry_flag == $past(dc_imm)
    && o_zero_flag == wz) else $error("immediate add wrong");
  chk_add_file: assert property (acc && op == OP_ADD_FILE && !dbit |=>
    {o_carry_flag, o_working_register} == $past(s_file) && o_zero_flag == wz)
    else $error("file add wrong");
  chk_and_imm: assert property (acc && op == OP_AND_IMM |=> o_zero_flag == wz
    && $stable(o_carry_flag) && $stable(o_digit_carry_flag)) else $error("and flags wrong");
  chk_file_write: assert property (acc && fop |=>
    o_file_we == $past(dbit) && o_file_addr == $past(fa)) else $error("file write wrong");
  chk_asr_file: assert property (acc && op == OP_ASR_FILE |=>
    o_carry_flag == $past(rd0) && (!$past(dbit) || o_file_wdata == $past(asr)))
    else $error("shift wrong");
endmodule : ase_exec_assertions

bind ase_exec ase_exec_assertions u_chk (.*);

//--- ase_pkg.sv
// Package for the add and shift execution datapath.
// Assumes a single core instruction clock; shared by the exec top and its ALU.
package ase_pkg;
  // ==========================================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int INSN_W = 14;
  localparam int ADDR_W = 7;
  localparam int PTR_W = 16;
  localparam int LIT6_W = 6;
  // ==========================================================================
  // Opcode fields: the upper six bits of the instruction word
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int PTR_SEL_BIT = 6;
  localparam int PTR_ZERO_BIT = 7;
  localparam int DC_BIT = 3;
  localparam logic [5:0] OP_ADD_IMM = 6'h3E;
  localparam logic [5:0] OP_AND_IMM = 6'h39;
  localparam logic [5:0] OP_ADD_PTR = 6'h31;
  localparam logic [5:0] OP_ADD_FILE = 6'h07;
  localparam logic [5:0] OP_ADDC_FILE = 6'h3D;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [5:0] OP_ASR_FILE = 6'h37;
  // ==========================================================================
  // Indirect access register addresses and reset values
  localparam logic [6:0] INDIRECT0_ADDR = 7'h00;
  localparam logic [6:0] INDIRECT1_ADDR = 7'h01;
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  // ==========================================================================
  typedef enum logic [2:0] {
    ASE_OP_NONE, ASE_OP_ADD, ASE_OP_ADDC, ASE_OP_AND, ASE_OP_ASR
  } ase_op_e;
endpackage : ase_pkg

//--- tb.sv
// Self-checking bench for the add and shift execution datapath.
// Assumes the bench plays the fetch stage and file memory itself.
`timescale 1ns/1ns
module tb;
  import ase_pkg::*;
  typedef struct packed {
    logic [13:0] insn;
    logic [7:0] rd;
    logic [7:0] w;
    logic [2:0] f;
    logic we;
    logic [7:0] wd;
  } ase_row_s;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  logic i_insn_valid = 1'b0;
  logic i_branch_taken = 1'b0;
  logic [13:0] i_insn = 14'h0;
  logic [7:0] i_file_rdata = 8'h00;
  logic o_file_we, o_carry_flag, o_digit_carry_flag, o_zero_flag, o_busy, o_nop_cycle;
  logic [6:0] o_file_addr;
  logic [7:0] o_file_wdata, o_working_register;
  logic [15:0] o_indirect_pointer0, o_indirect_pointer1;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ==========================================================
  // Rows run in order; each expects state left by the one before
  ase_row_s rows[13] = '{
    '{14'h3EFF, 8'h00, 8'hFF, 3'h0, 1'b0, 8'h00},
    '{14'h3E01, 8'h00, 8'h00, 3'h7, 1'b0, 8'h00},
    '{14'h3D10, 8'h0F, 8'h10, 3'h2, 1'b0, 8'h00},
    '{14'h07A2, 8'h88, 8'h10, 3'h0, 1'b1, 8'h98},
    '{14'h39F0, 8'h00, 8'h10, 3'h0, 1'b0, 8'h00},
    '{14'h05B3, 8'h0F, 8'h10, 3'h1, 1'b1, 8'h00},
    '{14'h3744, 8'h81, 8'hC0, 3'h4, 1'b0, 8'h00},
    '{14'h37C5, 8'h02, 8'hC0, 3'h0, 1'b1, 8'h01},
    '{14'h3DC6, 8'h40, 8'hC0, 3'h5, 1'b1, 8'h00},
    '{14'h3D07, 8'h00, 8'hC1, 3'h0, 1'b0, 8'h00},
    '{14'h3981, 8'h00, 8'h81, 3'h0, 1'b0, 8'h00},
    '{14'h0708, 8'h7F, 8'h00, 3'h7, 1'b0, 8'h00},
    '{14'h3000, 8'h00, 8'h00, 3'h7, 1'b0, 8'h00}};
  ase_exec u_dut (.*);
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic issue(input logic [13:0] insn, input logic [7:0] rd);
    @(posedge i_sys_clk);
    i_insn <= insn;
    i_file_rdata <= rd;
    i_insn_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_insn_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // A hang never reaches the closing report on its own
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    #1 cmp({3'h0, o_busy, o_working_register, o_carry_flag, o_digit_carry_flag,
      o_zero_flag, o_file_we}, 16'h0000);
    foreach (rows[i]) begin
      issue(rows[i].insn, rows[i].rd);
      cmp({4'h0, o_file_we, o_working_register, o_carry_flag, o_digit_carry_flag,
        o_zero_flag}, {4'h0, rows[i].we, rows[i].w, rows[i].f});
      if (rows[i].we) cmp({1'b0, o_file_addr, o_file_wdata}, {1'b0, rows[i].insn[6:0], rows[i].wd});
    end
    // Pointer adds: 0 - 1, 0 - 1 + 31, then a refused form
    issue(14'h313F, 8'h00);
    issue(14'h317F, 8'h00);
    issue(14'h315F, 8'h00);
    issue(14'h31DF, 8'h00);
    cmp(o_indirect_pointer0, 16'hFFFF);
    cmp(o_indirect_pointer1, 16'h001E);
    cmp({5'h00, o_carry_flag, o_digit_carry_flag, o_zero_flag, o_working_register}, 16'h0700);
    issue(14'h0700, 8'h01);
    cmp({15'h0, o_busy}, 16'h0001);
    @(posedge i_sys_clk);
    #1 cmp({15'h0, o_busy}, 16'h0000);
    issue(14'h0701, 8'h01);
    cmp({7'h0, o_busy, o_working_register}, 16'h0002);
    @(posedge i_sys_clk);
    i_insn <= 14'h39FF;
    i_branch_taken <= 1'b1;
    i_insn_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_insn <= 14'h3E01;
    i_branch_taken <= 1'b0;
    #1 cmp({14'h0, o_busy, o_nop_cycle}, 16'h0003);
    @(posedge i_sys_clk);
    i_insn_valid <= 1'b0;
    #1 cmp({6'h0, o_busy, o_nop_cycle, o_working_register}, 16'h0002);
    // Branch on top of an indirect access with the pointer top bit set: longest stall
    @(posedge i_sys_clk);
    i_insn <= 14'h0700;
    i_file_rdata <= 8'h01;
    i_branch_taken <= 1'b1;
    i_insn_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_branch_taken <= 1'b0;
    i_insn_valid <= 1'b0;
    repeat (2) begin
      #1 cmp({15'h0, o_busy}, 16'h0001);
      @(posedge i_sys_clk);
    end
    #1 cmp({8'h00, o_working_register}, 16'h0003);
    cmp({15'h0, o_busy}, 16'h0000);
    // Enable low: an offered instruction must leave the working register as it was
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    i_insn <= 14'h3E05;
    i_insn_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_ce <= 1'b1;
    i_insn_valid <= 1'b0;
    #1 cmp({8'h00, o_working_register}, 16'h0003);
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    @(posedge i_sys_clk);
    i_srst <= 1'b0;
    #1 cmp(o_indirect_pointer0 | {8'h00, o_working_register}, 16'h0000);
    end_sim();
  end
endmodule : tb
